// [dv/cod_exec_sink.sv]
`timescale 1ns/1ns
`default_nettype none
// execution unit stand-in: takes one decoded instruction per enabled edge
module cod_exec_sink (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        clkEn,
  input  wire logic        decValid,
  input  wire logic [7:0]  execClocks,
  output logic      [15:0] taken,
  output logic      [15:0] budget
);
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      taken  <= 16'h0000;
      budget <= 16'h0000;
    end else if (clkEn && decValid) begin
      taken  <= taken + 16'h0001;
      budget <= budget + {8'h00, execClocks};
    end
  end
endmodule // cod_exec_sink
`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; $display("BAD %0t mismatch", $time); end end
module testbench;
  import cod_pkg::*;
  logic sys_clk = 1'b0, reset = 1'b1, clkEn = 1'b1, instValid = 1'b0, protMode = 1'b0;
  logic [7:0] opcodeByte = 8'h00, modrmByte = 8'h00;
  logic decValid, wordOp, regIsDest, memOperand, signExtImm, modrmUsed, plusShiftCount, writesResult, notHandled;
  cod_op_type decOp;
  cod_shift_type shiftKind;
  logic [1:0] immBytes;
  logic [7:0] execClocks;
  logic [15:0] taken, budget, issued = 16'h0000, sumClk = 16'h0000;
  int fails = 0, comparisons = 0;
  cod_decode uut (.sys_clk(sys_clk), .reset(reset), .clkEn(clkEn), .instValid(instValid), .protMode(protMode),
    .opcodeByte(opcodeByte), .modrmByte(modrmByte), .decValid(decValid), .decOp(decOp), .shiftKind(shiftKind),
    .wordOp(wordOp), .regIsDest(regIsDest), .memOperand(memOperand), .signExtImm(signExtImm),
    .modrmUsed(modrmUsed), .plusShiftCount(plusShiftCount), .writesResult(writesResult),
    .notHandled(notHandled), .immBytes(immBytes), .execClocks(execClocks));
  cod_exec_sink sink (.sys_clk(sys_clk), .reset(reset), .clkEn(clkEn), .decValid(decValid),
    .execClocks(execClocks), .taken(taken), .budget(budget));
  initial forever #4 sys_clk = ~sys_clk;
  task automatic close_out;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one instruction in, answer read one edge later while it stands
  task automatic dec(input logic [7:0] op, input logic [7:0] m, input logic pm, input cod_op_type eo,
                     input logic [7:0] ec);
    @(posedge sys_clk);
    instValid <= 1'b1;
    opcodeByte <= op;
    modrmByte <= m;
    protMode <= pm;
    @(posedge sys_clk);
    instValid <= 1'b0;
    #1;
    issued = issued + 16'h0001;
    sumClk = sumClk + {8'h00, ec};
    `CHK(decValid, 1'b1)
    `CHK(decOp, eo)
    `CHK(execClocks, ec)
  endtask
  task automatic t_transfer;
    dec(8'h88, 8'hc0, 1'b0, OP_REG_TRANSFER, 8'h02);
    `CHK({regIsDest, memOperand, wordOp, modrmUsed}, 4'b0001)
    dec(8'h89, 8'h06, 1'b1, OP_REG_TRANSFER, 8'h03);
    `CHK({memOperand, wordOp}, 2'b11)
    dec(8'h8b, 8'h06, 1'b0, OP_REG_TRANSFER, 8'h05);
    `CHK({regIsDest, wordOp, memOperand}, 3'b111)
    @(posedge sys_clk);
    #1;
    `CHK({decValid, execClocks}, 9'h000)
  endtask
  task automatic t_segment;
    dec(8'h8e, 8'hd8, 1'b0, OP_SEG_LOAD, 8'h02);
    dec(8'h8e, 8'h1e, 1'b0, OP_SEG_LOAD, 8'h05);
    dec(8'h8e, 8'hd8, 1'b1, OP_SEG_LOAD, 8'h11);
    dec(8'h8e, 8'h1e, 1'b1, OP_SEG_LOAD, 8'h13);
    dec(8'h1f, 8'h00, 1'b0, OP_SEG_POP, 8'h05);
    dec(8'h07, 8'h00, 1'b1, OP_SEG_POP, 8'h14);
    dec(8'h0f, 8'h00, 1'b0, OP_NONE, 8'h00);
    `CHK({notHandled, immBytes}, 3'b100)
  endtask
  task automatic t_misc;
    dec(8'hc5, 8'h06, 1'b0, OP_FAR_POINTER_LOAD_DATA_SEG, 8'h07);
    dec(8'hc5, 8'h06, 1'b1, OP_FAR_POINTER_LOAD_DATA_SEG, 8'h15);
    dec(8'hc5, 8'hc0, 1'b0, OP_NONE, 8'h00);
    `CHK(notHandled, 1'b1)
    dec(8'hd7, 8'h00, 1'b0, OP_TABLE_LOOKUP, 8'h05);
    dec(8'hd7, 8'h00, 1'b1, OP_TABLE_LOOKUP, 8'h05);
    dec(8'he7, 8'h40, 1'b1, OP_OUT_FIXED, 8'h03);
    `CHK({immBytes, writesResult}, 3'b010)
    dec(8'he6, 8'h40, 1'b0, OP_OUT_FIXED, 8'h03);
    `CHK(wordOp, 1'b0)
    dec(8'h8d, 8'h06, 1'b0, OP_EFFECTIVE_OFFSET_LOAD, 8'h03);
    `CHK(memOperand, 1'b0)
    dec(8'h8d, 8'hc0, 1'b0, OP_NONE, 8'h00);
    // a live answer must outlast three disabled edges while a new opcode waits
    @(posedge sys_clk);
    instValid <= 1'b1;
    opcodeByte <= 8'h8d;
    modrmByte <= 8'h06;
    @(posedge sys_clk);
    clkEn <= 1'b0;
    opcodeByte <= 8'h88;
    modrmByte <= 8'hc0;
    repeat (3) @(posedge sys_clk);
    #1;
    issued = issued + 16'h0001;
    sumClk = sumClk + 16'h0003;
    `CHK({decValid, execClocks}, 9'h103)
    `CHK(decOp, OP_EFFECTIVE_OFFSET_LOAD)
    @(posedge sys_clk);
    clkEn <= 1'b1;
    instValid <= 1'b0;
  endtask
  task automatic t_alu;
    dec(8'h12, 8'hc1, 1'b0, OP_ADD_CARRY, 8'h02);
    `CHK({regIsDest, wordOp}, 2'b10)
    dec(8'h11, 8'h07, 1'b1, OP_ADD_CARRY, 8'h07);
    `CHK({regIsDest, wordOp, memOperand}, 3'b011)
    dec(8'h1a, 8'hc0, 1'b0, OP_MINUS_WITH_BORROW, 8'h02);
    dec(8'h80, 8'hd8, 1'b0, OP_MINUS_WITH_BORROW, 8'h03);
    dec(8'h2b, 8'h06, 1'b0, OP_SUBTRACT, 8'h07);
    dec(8'h81, 8'he8, 1'b0, OP_SUBTRACT, 8'h03);
    dec(8'h81, 8'hf8, 1'b0, OP_COMPARE_OP, 8'h03);
    `CHK({immBytes, signExtImm, writesResult}, 4'b1000)
    dec(8'h83, 8'h38, 1'b0, OP_COMPARE_OP, 8'h06);
    `CHK({immBytes, signExtImm}, 3'b011)
    dec(8'h80, 8'hf8, 1'b0, OP_COMPARE_OP, 8'h03);
    `CHK({immBytes, signExtImm}, 3'b010)
    dec(8'h82, 8'h38, 1'b0, OP_COMPARE_OP, 8'h06);
    `CHK({immBytes, signExtImm, wordOp}, 4'b0100)
  endtask
  task automatic t_muldiv;
    cod_op_type ops [3] = '{OP_UNSIGNED_PRODUCT, OP_UNSIGNED_QUOTIENT, OP_SIGNED_QUOTIENT};
    logic [2:0] mids [3] = '{3'h4, 3'h6, 3'h7};
    // byte reg, word reg, byte mem, word mem
    logic [7:0] clks [3][4] = '{'{8'h0d, 8'h15, 8'h10, 8'h18}, '{8'h0e, 8'h16, 8'h11, 8'h19},
                               '{8'h11, 8'h19, 8'h14, 8'h1c}};
    for (int i = 0; i < 3; i++) begin
      for (int k = 0; k < 4; k++) begin
        dec({7'h7b, k[0]}, {{2{!k[1]}}, mids[i], 3'h1}, k[1], ops[i], clks[i][k]);
      end
    end
    dec(8'h69, 8'hc8, 1'b0, OP_SIGNED_PRODUCT, 8'h15);
    `CHK(immBytes, 2'h2)
    dec(8'h6b, 8'h0e, 1'b1, OP_SIGNED_PRODUCT, 8'h18);
    `CHK({immBytes, signExtImm}, 3'b011)
    dec(8'hd4, 8'h0a, 1'b0, OP_BCD_FIX_PRODUCT, 8'h10);
    dec(8'hd5, 8'h0a, 1'b1, OP_BCD_PREP_QUOTIENT, 8'h0e);
    dec(8'hd4, 8'h08, 1'b0, OP_NONE, 8'h00);
    dec(8'hf7, 8'hc0, 1'b0, OP_BIT_TEST, 8'h03);
    `CHK({immBytes, writesResult}, 3'b100)
    dec(8'hf6, 8'h1e, 1'b0, OP_NEGATE, 8'h07);
    dec(8'hf7, 8'he8, 1'b0, OP_SIGNED_PRODUCT, 8'h15);
    dec(8'hf6, 8'hc8, 1'b0, OP_NONE, 8'h00);
    `CHK(notHandled, 1'b1)
  endtask
  task automatic t_logic;
    cod_shift_type kinds [8] = '{SH_ROTATE_LEFT, SH_ROTATE_RIGHT, SH_CARRY_ROTATE_LEFT, SH_CARRY_ROTATE_RIGHT,
                                 SH_SHIFT_LEFT, SH_LOGICAL_SHIFT_RIGHT, SH_ROTATE_LEFT, SH_ARITH_SHIFT_RIGHT};
    for (int t = 0; t < 8; t++) begin
      // field 110 has no kind and must fall out of the subset
      dec(8'hd1, {2'b11, t[2:0], 3'h2}, 1'b0, (t == 6) ? OP_NONE : OP_SHIFT, (t == 6) ? 8'h00 : 8'h02);
      `CHK(shiftKind, kinds[t])
      `CHK({plusShiftCount, immBytes}, 3'b000)
    end
    // count-driven forms: base count plus a flag for the per-bit clocks
    dec(8'hd3, 8'h07, 1'b0, OP_SHIFT, 8'h08);
    `CHK({plusShiftCount, immBytes, shiftKind}, 6'b100000)
    dec(8'hc0, 8'hf8, 1'b1, OP_SHIFT, 8'h05);
    `CHK({plusShiftCount, immBytes, wordOp}, 4'b1010)
    `CHK(shiftKind, SH_ARITH_SHIFT_RIGHT)
    dec(8'h84, 8'hc0, 1'b0, OP_BIT_TEST, 8'h02);
    `CHK(writesResult, 1'b0)
    dec(8'h85, 8'h06, 1'b0, OP_BIT_TEST, 8'h06);
    dec(8'hf6, 8'hd0, 1'b0, OP_INVERT, 8'h02);
    dec(8'hf7, 8'h16, 1'b1, OP_INVERT, 8'h07);
    dec(8'ha6, 8'h00, 1'b0, OP_BLOCK_COMPARE, 8'h08);
    dec(8'ha7, 8'h00, 1'b1, OP_BLOCK_COMPARE, 8'h08);
    `CHK(wordOp, 1'b1)
    dec(8'hae, 8'h00, 1'b1, OP_BLOCK_SCAN, 8'h07);
    dec(8'haf, 8'h00, 1'b0, OP_BLOCK_SCAN, 8'h07);
    dec(8'h6c, 8'h00, 1'b0, OP_PORT_BLOCK_INPUT, 8'h05);
    `CHK(wordOp, 1'b0)
    dec(8'h6d, 8'h00, 1'b1, OP_PORT_BLOCK_INPUT, 8'h05);
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    t_transfer();
    t_segment();
    t_misc();
    t_alu();
    t_muldiv();
    t_logic();
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK(taken, issued)
    `CHK(budget, sumClk)
    close_out();
  end
  // the run needs about 150 cycles; far beyond that means a hang
  initial begin
    #(8 * 5000);
    fails++;
    close_out();
  end
endmodule // testbench
`default_nettype wire

// [src/cod_decode.sv]
`timescale 1ns/1ns
`default_nettype none
module cod_decode (
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  input  wire logic                   clkEn,
  input  wire logic                   instValid,
  input  wire logic                   protMode,
  input  wire logic [7:0]             opcodeByte,
  input  wire logic [7:0]             modrmByte,
  output logic                        decValid,
  output cod_pkg::cod_op_type         decOp,
  output cod_pkg::cod_shift_type      shiftKind,
  output logic                        wordOp,
  output logic                        regIsDest,
  output logic                        memOperand,
  output logic                        signExtImm,
  output logic                        modrmUsed,
  output logic                        plusShiftCount,
  output logic                        writesResult,
  output logic                        notHandled,
  output logic [1:0]                  immBytes,
  output logic [7:0]                  execClocks
);
  import cod_pkg::*;

  cod_state_type s;
  cod_state_type next_s;
  logic          isMem;
  logic [2:0]    mid;

  assign isMem = (modrmByte[MOD_MSB:MOD_LSB] != MOD_REGISTER);
  assign mid   = modrmByte[MID_MSB:MID_LSB];

  function automatic logic [7:0] pick(input logic m, input logic [7:0] r, input logic [7:0] x);
    return m ? x : r;
  endfunction

  always_comb begin
    next_s = s;
    if (clkEn) begin
      next_s                = '0;
      next_s.decValid       = instValid;
      next_s.op             = OP_NONE;
      next_s.shiftKind      = SH_ROTATE_LEFT;
      next_s.wordOp         = opcodeByte[0];
      next_s.writesResult   = 1'b1;
      unique case (opcodeByte)
        8'h88, 8'h89: begin
          next_s.op         = OP_REG_TRANSFER;
          next_s.modrmUsed  = 1'b1;
          next_s.regIsDest  = opcodeByte[1];
          next_s.execClocks = pick(isMem, CLK_XFER_REG, CLK_XFER_MEM);
        end
        8'h8a, 8'h8b: begin
          next_s.op         = OP_REG_TRANSFER;
          next_s.modrmUsed  = 1'b1;
          next_s.regIsDest  = opcodeByte[1];
          next_s.execClocks = pick(isMem, CLK_XFER_REG, CLK_LOADREG_MEM);
        end
        8'h8e: begin
          next_s.op         = OP_SEG_LOAD;
          next_s.modrmUsed  = 1'b1;
          next_s.wordOp     = 1'b1;
          next_s.regIsDest  = 1'b1;
          next_s.execClocks = protMode ? pick(isMem, CLK_SEGLD_PROT_REG, CLK_SEGLD_PROT_MEM)
                                       : pick(isMem, CLK_SEGLD_REAL_REG, CLK_SEGLD_REAL_MEM);
        end
        // reg field 01 (0x0f) is left to the default arm
        8'h07, 8'h17, 8'h1f: begin
          next_s.op         = OP_SEG_POP;
          next_s.wordOp     = 1'b1;
          next_s.execClocks = protMode ? CLK_SEGPOP_PROT : CLK_SEGPOP_REAL;
        end
        8'hc5: begin
          next_s.op         = OP_FAR_POINTER_LOAD_DATA_SEG;
          next_s.modrmUsed  = 1'b1;
          next_s.wordOp     = 1'b1;
          next_s.regIsDest  = 1'b1;
          next_s.notHandled = !isMem;
          next_s.execClocks = protMode ? CLK_FARLD_PROT : CLK_FARLD_REAL;
        end
        8'hd7: begin
          next_s.op         = OP_TABLE_LOOKUP;
          next_s.wordOp     = 1'b0;
          next_s.execClocks = CLK_LOOKUP;
        end
        8'he6, 8'he7: begin
          next_s.op           = OP_OUT_FIXED;
          next_s.immBytes     = 2'h1;
          next_s.writesResult = 1'b0;
          next_s.execClocks   = CLK_OUT_FIXED;
        end
        8'h10, 8'h11, 8'h12, 8'h13, 8'h18, 8'h19, 8'h1a, 8'h1b,
        8'h28, 8'h29, 8'h2a, 8'h2b: begin
          unique case (opcodeByte[5:3])
            3'h2:    next_s.op = OP_ADD_CARRY;
            3'h3:    next_s.op = OP_MINUS_WITH_BORROW;
            default: next_s.op = OP_SUBTRACT;
          endcase
          next_s.modrmUsed  = 1'b1;
          next_s.regIsDest  = opcodeByte[1];
          next_s.execClocks = pick(isMem, CLK_ALU_REG, CLK_ALU_MEM);
        end
        8'h80, 8'h81, 8'h82, 8'h83: begin
          unique case (mid)
            3'h0: next_s.op = OP_ADD;
            3'h1: next_s.op = OP_OR;
            3'h2: next_s.op = OP_ADD_CARRY;
            3'h3: next_s.op = OP_MINUS_WITH_BORROW;
            3'h4: next_s.op = OP_AND;
            3'h5: next_s.op = OP_SUBTRACT;
            3'h6: next_s.op = OP_XOR;
            3'h7: next_s.op = OP_COMPARE_OP;
          endcase
          next_s.modrmUsed    = 1'b1;
          next_s.immBytes     = (opcodeByte[1:0] == SW_FULL_WORD) ? 2'h2 : 2'h1;
          next_s.signExtImm   = opcodeByte[1] & opcodeByte[0];
          next_s.writesResult = (mid != 3'h7);
          next_s.execClocks   = (mid == 3'h7) ? pick(isMem, CLK_IMM_REG, CLK_CMP_TEST_MEM)
                                              : pick(isMem, CLK_IMM_REG, CLK_IMM_MEM);
        end
        8'hf6, 8'hf7: begin
          next_s.modrmUsed = 1'b1;
          unique case (mid)
            3'h0: begin
              next_s.op           = OP_BIT_TEST;
              next_s.writesResult = 1'b0;
              next_s.immBytes     = opcodeByte[0] ? 2'h2 : 2'h1;
              next_s.execClocks   = pick(isMem, CLK_IMM_REG, CLK_CMP_TEST_MEM);
            end
            3'h1: next_s.notHandled = 1'b1;
            3'h2: begin
              next_s.op         = OP_INVERT;
              next_s.execClocks = pick(isMem, CLK_ALU_REG, CLK_ALU_MEM);
            end
            3'h3: begin
              next_s.op         = OP_NEGATE;
              next_s.execClocks = pick(isMem, CLK_ALU_REG, CLK_ALU_MEM);
            end
            3'h4, 3'h5: begin
              next_s.op         = (mid == 3'h4) ? OP_UNSIGNED_PRODUCT : OP_SIGNED_PRODUCT;
              next_s.execClocks = opcodeByte[0] ? pick(isMem, CLK_MUL_REG_WORD, CLK_MUL_MEM_WORD)
                                                : pick(isMem, CLK_MUL_REG_BYTE, CLK_MUL_MEM_BYTE);
            end
            3'h6: begin
              next_s.op         = OP_UNSIGNED_QUOTIENT;
              next_s.execClocks = opcodeByte[0] ? pick(isMem, CLK_DIV_REG_WORD, CLK_DIV_MEM_WORD)
                                                : pick(isMem, CLK_DIV_REG_BYTE, CLK_DIV_MEM_BYTE);
            end
            3'h7: begin
              next_s.op         = OP_SIGNED_QUOTIENT;
              next_s.execClocks = opcodeByte[0] ? pick(isMem, CLK_SIGNED_QUOTIENT_REG_WORD, CLK_SIGNED_QUOTIENT_MEM_WORD)
                                                : pick(isMem, CLK_SIGNED_QUOTIENT_REG_BYTE, CLK_SIGNED_QUOTIENT_MEM_BYTE);
            end
          endcase
        end
        8'h69, 8'h6b: begin
          next_s.op         = OP_SIGNED_PRODUCT;
          next_s.modrmUsed  = 1'b1;
          next_s.regIsDest  = 1'b1;
          next_s.signExtImm = opcodeByte[1];
          next_s.immBytes   = opcodeByte[1] ? 2'h1 : 2'h2;
          next_s.execClocks = pick(isMem, CLK_IMULIMM_REG, CLK_IMULIMM_MEM);
        end
        // second byte sits in the addressing byte slot and carries the base
        8'hd4, 8'hd5: begin
          next_s.op         = opcodeByte[0] ? OP_BCD_PREP_QUOTIENT : OP_BCD_FIX_PRODUCT;
          next_s.wordOp     = 1'b0;
          next_s.immBytes   = 2'h1;
          next_s.notHandled = (modrmByte != BCD_BASE);
          next_s.execClocks = opcodeByte[0] ? CLK_BCD_PREP : CLK_BCD_FIX;
        end
        8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hc0, 8'hc1: begin
          next_s.op        = OP_SHIFT;
          next_s.modrmUsed = 1'b1;
          unique case (mid)
            3'h0: next_s.shiftKind = SH_ROTATE_LEFT;
            3'h1: next_s.shiftKind = SH_ROTATE_RIGHT;
            3'h2: next_s.shiftKind = SH_CARRY_ROTATE_LEFT;
            3'h3: next_s.shiftKind = SH_CARRY_ROTATE_RIGHT;
            3'h4: next_s.shiftKind = SH_SHIFT_LEFT;
            3'h5: next_s.shiftKind = SH_LOGICAL_SHIFT_RIGHT;
            3'h6: next_s.notHandled = 1'b1;
            3'h7: next_s.shiftKind = SH_ARITH_SHIFT_RIGHT;
          endcase
          // count-dependent forms report the base only; the unit adds one per bit shifted
          next_s.plusShiftCount = !(opcodeByte[7:1] == 7'h68);
          next_s.immBytes       = (opcodeByte[7:1] == 7'h60) ? 2'h1 : 2'h0;
          next_s.execClocks     = (opcodeByte[7:1] == 7'h68) ? pick(isMem, CLK_SHIFT1_REG, CLK_SHIFT1_MEM)
                                                             : pick(isMem, CLK_SHIFTN_REG, CLK_SHIFTN_MEM);
        end
        8'h84, 8'h85: begin
          next_s.op           = OP_BIT_TEST;
          next_s.modrmUsed    = 1'b1;
          next_s.writesResult = 1'b0;
          next_s.execClocks   = pick(isMem, CLK_ALU_REG, CLK_CMP_TEST_MEM);
        end
        8'ha6, 8'ha7: begin
          next_s.op           = OP_BLOCK_COMPARE;
          next_s.writesResult = 1'b0;
          next_s.execClocks   = CLK_BLOCK_COMPARE;
        end
        8'hae, 8'haf: begin
          next_s.op           = OP_BLOCK_SCAN;
          next_s.writesResult = 1'b0;
          next_s.execClocks   = CLK_BLOCK_SCAN;
        end
        8'h6c, 8'h6d: begin
          next_s.op         = OP_PORT_BLOCK_INPUT;
          next_s.execClocks = CLK_PORT_BLOCK_IN;
        end
        8'h8d: begin
          next_s.op         = OP_EFFECTIVE_OFFSET_LOAD;
          next_s.wordOp     = 1'b1;
          next_s.regIsDest  = 1'b1;
          next_s.notHandled = !isMem; // a register source has no address to take
          next_s.execClocks = CLK_EA_LOAD;
        end
        default: next_s.notHandled = 1'b1;
      endcase
      // address-only load never touches the operand
      next_s.memOperand = next_s.modrmUsed && isMem && (next_s.op != OP_EFFECTIVE_OFFSET_LOAD);
      if (next_s.notHandled || !instValid) begin
        next_s.op             = OP_NONE;
        next_s.shiftKind      = SH_ROTATE_LEFT;
        next_s.execClocks     = 8'h00;
        next_s.immBytes       = 2'h0;
        next_s.memOperand     = 1'b0;
        next_s.plusShiftCount = 1'b0;
        next_s.notHandled     = next_s.notHandled && instValid;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign decValid       = s.decValid;
  assign decOp          = s.op;
  assign shiftKind      = s.shiftKind;
  assign wordOp         = s.wordOp;
  assign regIsDest      = s.regIsDest;
  assign memOperand     = s.memOperand;
  assign signExtImm     = s.signExtImm;
  assign modrmUsed      = s.modrmUsed;
  assign plusShiftCount = s.plusShiftCount;
  assign writesResult   = s.writesResult;
  assign notHandled     = s.notHandled;
  assign immBytes       = s.immBytes;
  assign execClocks     = s.execClocks;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence sqTake(logic [7:0] code);
    clkEn && instValid && opcodeByte == code;
  endsequence

  sequence sqRegMode;
    modrmByte[MOD_MSB:MOD_LSB] == MOD_REGISTER;
  endsequence

  AST_XFER_CLOCKS: assert property (sqTake(8'h88) |=> decValid && execClocks ==
    (($past(modrmByte[MOD_MSB:MOD_LSB]) == MOD_REGISTER) ? CLK_XFER_REG : CLK_XFER_MEM))
    else $error("transfer clock count wrong");
  AST_SEGLD_MODE: assert property (sqTake(8'h8e) ##0 sqRegMode |=>
    execClocks == ($past(protMode) ? CLK_SEGLD_PROT_REG : CLK_SEGLD_REAL_REG))
    else $error("segment load clock count wrong");
  AST_SEGPOP_ILLEGAL: assert property (sqTake(8'h0f) |=> notHandled && decOp == OP_NONE)
    else $error("illegal segment pop accepted");
  AST_FARLD_REG: assert property (sqTake(8'hc5) ##0 sqRegMode |=> notHandled && execClocks == 8'h00)
    else $error("far pointer load with register operand accepted");
  AST_GROUP_IMM: assert property ((clkEn && instValid && opcodeByte[7:2] == 6'h20) |=>
    immBytes == (($past(opcodeByte[1:0]) == SW_FULL_WORD) ? 2'h2 : 2'h1))
    else $error("immediate byte count wrong");
  AST_MUL_WORD: assert property (sqTake(8'hf7) ##0 mid == 3'h4 |=> decOp == OP_UNSIGNED_PRODUCT &&
    execClocks == (($past(modrmByte[MOD_MSB:MOD_LSB]) == MOD_REGISTER) ? CLK_MUL_REG_WORD : CLK_MUL_MEM_WORD))
    else $error("word product clock count wrong");
  AST_TEST_NOWRITE: assert property (sqTake(8'h85) |=> !writesResult && decOp == OP_BIT_TEST)
    else $error("bit test writes a result");
  AST_DIRECTION: assert property ((clkEn && instValid && opcodeByte[7:2] == 6'h06) |=>
    regIsDest == $past(opcodeByte[1]) && wordOp == $past(opcodeByte[0]))
    else $error("direction or width bit misdecoded");
  AST_EA_NOMEM: assert property (sqTake(8'h8d) |=> !memOperand)
    else $error("address load marked as memory access");
  AST_HOLD: assert property (!clkEn |=> $stable(execClocks) && $stable(decValid) && $stable(decOp))
    else $error("state moved while clock enable low");
  AST_UNHANDLED: assert property (notHandled |-> decValid && decOp == OP_NONE)
    else $error("unhandled flag without empty operation");

endmodule // cod_decode
`default_nettype wire

// [src/cod_pkg.sv]
package cod_pkg;

  typedef enum logic [4:0] {
    OP_NONE, OP_REG_TRANSFER, OP_SEG_LOAD, OP_SEG_POP, OP_FAR_POINTER_LOAD_DATA_SEG,
    OP_TABLE_LOOKUP, OP_OUT_FIXED, OP_ADD, OP_OR, OP_ADD_CARRY, OP_MINUS_WITH_BORROW,
    OP_AND, OP_SUBTRACT, OP_XOR, OP_COMPARE_OP, OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT,
    OP_UNSIGNED_QUOTIENT, OP_SIGNED_QUOTIENT, OP_NEGATE, OP_INVERT, OP_BIT_TEST,
    OP_BCD_FIX_PRODUCT, OP_BCD_PREP_QUOTIENT, OP_SHIFT, OP_BLOCK_COMPARE, OP_BLOCK_SCAN,
    OP_PORT_BLOCK_INPUT, OP_EFFECTIVE_OFFSET_LOAD
  } cod_op_type;

  typedef enum logic [2:0] {
    SH_ROTATE_LEFT, SH_ROTATE_RIGHT, SH_CARRY_ROTATE_LEFT, SH_CARRY_ROTATE_RIGHT,
    SH_SHIFT_LEFT, SH_LOGICAL_SHIFT_RIGHT, SH_ARITH_SHIFT_RIGHT
  } cod_shift_type;

  typedef struct packed {
    logic          decValid;
    cod_op_type    op;
    cod_shift_type shiftKind;
    logic          wordOp;
    logic          regIsDest;
    logic          memOperand;
    logic          signExtImm;
    logic          modrmUsed;
    logic          plusShiftCount;
    logic          writesResult;
    logic          notHandled;
    logic [1:0]    immBytes;
    logic [7:0]    execClocks;
  } cod_state_type;

  // addressing byte fields
  localparam int         MOD_MSB      = 7;
  localparam int         MOD_LSB      = 6;
  localparam int         MID_MSB      = 5;
  localparam int         MID_LSB      = 3;
  localparam logic [1:0] MOD_REGISTER = 2'h3;
  localparam logic [1:0] SW_FULL_WORD = 2'h1;
  localparam logic [7:0] BCD_BASE     = 8'h0a;

  // execution clock counts
  localparam logic [7:0] CLK_XFER_REG       = 8'h02;
  localparam logic [7:0] CLK_XFER_MEM       = 8'h03;
  localparam logic [7:0] CLK_LOADREG_MEM    = 8'h05;
  localparam logic [7:0] CLK_SEGLD_REAL_REG = 8'h02;
  localparam logic [7:0] CLK_SEGLD_REAL_MEM = 8'h05;
  localparam logic [7:0] CLK_SEGLD_PROT_REG = 8'h11;
  localparam logic [7:0] CLK_SEGLD_PROT_MEM = 8'h13;
  localparam logic [7:0] CLK_SEGPOP_REAL    = 8'h05;
  localparam logic [7:0] CLK_SEGPOP_PROT    = 8'h14;
  localparam logic [7:0] CLK_FARLD_REAL     = 8'h07;
  localparam logic [7:0] CLK_FARLD_PROT     = 8'h15;
  localparam logic [7:0] CLK_LOOKUP         = 8'h05;
  localparam logic [7:0] CLK_OUT_FIXED      = 8'h03;
  localparam logic [7:0] CLK_ALU_REG        = 8'h02;
  localparam logic [7:0] CLK_ALU_MEM        = 8'h07;
  localparam logic [7:0] CLK_IMM_REG        = 8'h03;
  localparam logic [7:0] CLK_IMM_MEM        = 8'h07;
  localparam logic [7:0] CLK_CMP_TEST_MEM   = 8'h06;
  localparam logic [7:0] CLK_MUL_REG_BYTE   = 8'h0d;
  localparam logic [7:0] CLK_MUL_REG_WORD   = 8'h15;
  localparam logic [7:0] CLK_MUL_MEM_BYTE   = 8'h10;
  localparam logic [7:0] CLK_MUL_MEM_WORD   = 8'h18;
  localparam logic [7:0] CLK_DIV_REG_BYTE   = 8'h0e;
  localparam logic [7:0] CLK_DIV_REG_WORD   = 8'h16;
  localparam logic [7:0] CLK_DIV_MEM_BYTE   = 8'h11;
  localparam logic [7:0] CLK_DIV_MEM_WORD   = 8'h19;
  localparam logic [7:0] CLK_SIGNED_QUOTIENT_REG_BYTE  = 8'h11;
  localparam logic [7:0] CLK_SIGNED_QUOTIENT_REG_WORD  = 8'h19;
  localparam logic [7:0] CLK_SIGNED_QUOTIENT_MEM_BYTE  = 8'h14;
  localparam logic [7:0] CLK_SIGNED_QUOTIENT_MEM_WORD  = 8'h1c;
  localparam logic [7:0] CLK_IMULIMM_REG    = 8'h15;
  localparam logic [7:0] CLK_IMULIMM_MEM    = 8'h18;
  localparam logic [7:0] CLK_BCD_FIX        = 8'h10;
  localparam logic [7:0] CLK_BCD_PREP       = 8'h0e;
  localparam logic [7:0] CLK_SHIFT1_REG     = 8'h02;
  localparam logic [7:0] CLK_SHIFT1_MEM     = 8'h07;
  localparam logic [7:0] CLK_SHIFTN_REG     = 8'h05;
  localparam logic [7:0] CLK_SHIFTN_MEM     = 8'h08;
  localparam logic [7:0] CLK_BLOCK_COMPARE  = 8'h08;
  localparam logic [7:0] CLK_BLOCK_SCAN     = 8'h07;
  localparam logic [7:0] CLK_PORT_BLOCK_IN  = 8'h05;
  localparam logic [7:0] CLK_EA_LOAD        = 8'h03;

endpackage
